// file: design/setc_ctrl.sv
// Spindle emergency-stop supervision and tuning parameter decode.
// Behaviour
// - A notch filter is enabled only from 50 Hz to 2250 Hz; zero disables.
// - Synchronization position gain applies only while control mode equals 001.
// - Function word four bit 4 starts high-gain tracking in synchronization.
// - Function word four bit 2 selects excitation rate two.
// - Function word four bit 1 selects speed loop gain set two.
// - Function word five bit 8 allows coil changeover during stop deceleration.
// - Ready is forced off once the gate-off delay has elapsed.
// - A gate-off delay of zero means 7000 ms.
// - If delay expires while still turning and the time constant is not longer, the dynamic brake stops it.
// - Deceleration time constant is from maximum speed; zero means 7000 ms.
// - Emergency deceleration uses one fixed slope from any starting speed.
// - Time constant longer than gate delay lets the motor coast.
// - Function word six bit D selects high-response acceleration.
// - High-response selection is ignored in orientation and interpolation modes.
// - High-response mode scales lead compensation by the scale setting.
// - Alarm 23 rises when speed drops under the allowed share.
// - A slowdown width of 0 acts as 85 percent.
// - A slowdown width of -1 disables the slowdown check.
// - Stop input, controller power-down or unit alarm starts stop deceleration.
`timescale 1ns/1ps
module setc_ctrl
    import setc_pkg::*;
#(
    parameter int unsigned P_CYC_PER_MS = CYC_PER_MS
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic [15:0] i_ctrl_in4,
    input  wire logic        i_orienting,
    input  wire logic [15:0] i_speed_cmd,
    input  wire logic [15:0] i_speed_fb,
    input  wire logic        i_estop,
    input  wire logic        i_nc_power_down,
    input  wire logic        i_unit_alarm,
    output setc_tune_s       o_tune,
    output setc_stop_s       o_stop,
    output logic      [15:0] o_decel_ref,
    output logic      [7:0]  o_alarm_code
);

    if (P_CYC_PER_MS < 1 || P_CYC_PER_MS > 131071) begin : g_chk
        $error("P_CYC_PER_MS must lie between 1 and 131071.");
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: waitrequest drops in the cycle after the request.

    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic [15:0] cfg_ff [CFG_COUNT];
    logic [31:0] nxt_rdata;
    wire  logic        bus_req    = i_avs_read | i_avs_write;
    wire  logic        wr_fire    = i_avs_write & ack_ff;
    wire  logic [3:0]  addr_idx   = i_avs_address[5:2];
    wire  logic        cfg_hit    = addr_idx < 4'(CFG_COUNT);
    wire  logic        status_hit = i_avs_address == OFS_STATUS;
    wire  logic        ref_hit    = i_avs_address == OFS_DECEL_REF;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
            if (i_avs_read & ~ack_ff) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign o_avs_waitrequest = ~ack_ff;
    assign o_avs_readdata    = rdata_ff;

    for (genvar g = 0; g < CFG_COUNT; g++) begin : g_cfg
        wire logic hit = wr_fire & cfg_hit & (addr_idx == 4'(g));
        always_ff @(posedge i_clk_sys) begin
            if (i_srst) begin
                cfg_ff[g] <= CFG_RST[g];
            end else if (hit) begin
                if (i_avs_byteenable[0]) begin
                    cfg_ff[g][7:0] <= i_avs_writedata[7:0];
                end
                if (i_avs_byteenable[1]) begin
                    cfg_ff[g][15:8] <= i_avs_writedata[15:8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stop request pins: three flops, a change counts when two agree.

    wire  logic [2:0] pin_raw = {i_unit_alarm, i_nc_power_down, i_estop};
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] sync3_ff;
    logic [2:0] pin_ff;

    for (genvar p = 0; p < 3; p++) begin : g_pin
        always_ff @(posedge i_clk_sys) begin
            if (i_srst) begin
                sync1_ff[p] <= 1'b0;
                sync2_ff[p] <= 1'b0;
                sync3_ff[p] <= 1'b0;
                pin_ff[p]   <= 1'b0;
            end else begin
                sync1_ff[p] <= pin_raw[p];
                sync2_ff[p] <= sync1_ff[p];
                sync3_ff[p] <= sync2_ff[p];
                if (sync2_ff[p] == sync3_ff[p]) begin
                    pin_ff[p] <= sync3_ff[p];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tuning decode from the parameter words and the commanded mode.

    wire  logic [2:0]  mode      = i_ctrl_in4[2:0];
    wire  logic        sync_mode = mode == MODE_SYNC;
    wire  logic        interp    = sync_mode | (mode == MODE_INTERP_A)
                                   | (mode == MODE_INTERP_B);
    wire  logic [15:0] func4     = cfg_ff[IDX_FUNC_FOUR];
    wire  logic [15:0] func6     = cfg_ff[IDX_FUNC_SIX];
    wire  logic        fast_on   = func6[BIT_FAST_ACCEL]
                                   & ~interp & ~i_orienting;
    logic [3:0] notch_on;
    setc_tune_s tune_ff;
    setc_tune_s nxt_tune;

    for (genvar n = 0; n < 4; n++) begin : g_notch
        assign notch_on[n] = (cfg_ff[n] >= NOTCH_MIN_HZ)
                             & (cfg_ff[n] <= NOTCH_MAX_HZ);
    end

    assign nxt_tune.notch_en           = notch_on;
    assign nxt_tune.sync_gain_on       = sync_mode;
    assign nxt_tune.pos_gain           = sync_mode ?
                                         cfg_ff[IDX_SYNC_GAIN][7:0] :
                                         8'h00;
    assign nxt_tune.high_gain_tracking = sync_mode
                                         & func4[BIT_HIGH_GAIN];
    assign nxt_tune.excite_rate_two    = func4[BIT_EXCITE_TWO];
    assign nxt_tune.gain_set_two       = func4[BIT_GAIN_SET];
    assign nxt_tune.fast_accel         = fast_on;
    assign nxt_tune.lead_scale         = fast_on ?
                                         cfg_ff[IDX_LEAD_SCALE] :
                                         16'h0000;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            tune_ff <= '0;
        end else begin
            tune_ff <= nxt_tune;
        end
    end

    assign o_tune = tune_ff;

    ////////////////////////////////////////////////////////////////////////
    // Slowdown check: feedback times 100 against command times share.

    logic        alarm_ff;
    wire  logic [15:0] slow_w   = cfg_ff[IDX_SLOW_WIDTH];
    wire  logic        slow_off = slow_w == SLOW_DISABLE;
    wire  logic [6:0]  slow_pct = (slow_w == 16'h0000) ? SLOW_DEFAULT_PCT :
                                  (slow_w > 16'(PCT_FULL)) ? PCT_FULL :
                                  slow_w[6:0];
    wire  logic [6:0]  low_pct  = PCT_FULL - slow_pct;
    wire  logic [23:0] fb_scl   = 24'(i_speed_fb) * 24'(PCT_FULL);
    wire  logic [23:0] low_lim  = 24'(i_speed_cmd) * 24'(low_pct);
    setc_state_e state_ff;
    wire  logic        slow_trip = ~slow_off & (i_speed_cmd != 16'h0000)
                                   & (state_ff == ST_NORMAL)
                                   & (fb_scl <= low_lim);
    wire  logic        alarm_clr = wr_fire & status_hit
                                   & i_avs_byteenable[0]
                                   & i_avs_writedata[STB_ALARM];

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            alarm_ff <= 1'b0;
        end else begin
            alarm_ff <= slow_trip | (alarm_ff & ~alarm_clr);
        end
    end

    assign o_alarm_code = alarm_ff ? ALARM_SPEED_ERR : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Emergency stop: fixed-slope ramp, gate-off timer, brake or coast.

    wire  logic [15:0] gate_cfg = cfg_ff[IDX_GATE_DELAY];
    wire  logic [15:0] gate_ms  = (gate_cfg == 16'h0000) ?
                                  ESTOP_DEFAULT_MS : gate_cfg;
    wire  logic [15:0] tc_raw   = cfg_ff[IDX_DECEL_TC];
    wire  logic [15:0] tc_abs   = tc_raw[15] ? 16'(-tc_raw) : tc_raw;
    wire  logic [15:0] tc_ms    = (tc_abs == 16'h0000) ?
                                  ESTOP_DEFAULT_MS : tc_abs;
    wire  logic        coast_sel = tc_ms > gate_ms;
    wire  logic [31:0] tc_cyc   = 32'(tc_ms) * 32'(P_CYC_PER_MS);
    wire  logic        cause    = (|pin_ff) | alarm_ff;

    logic [16:0] pre_ff;
    logic [15:0] ms_ff;
    logic [31:0] acc_ff;
    logic [15:0] ref_ff;
    logic        brake_ff;
    logic        coast_ff;
    wire  logic        ms_tick  = pre_ff == 17'(P_CYC_PER_MS - 1);
    wire  logic        expire   = ms_ff >= gate_ms;
    wire  logic [31:0] acc_sum  = acc_ff + 32'(cfg_ff[IDX_MAX_SPEED]);
    wire  logic        step     = acc_sum >= tc_cyc;
    wire  logic        spinning = ref_ff != 16'h0000;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_ff <= ST_NORMAL;
            pre_ff   <= '0;
            ms_ff    <= '0;
            acc_ff   <= '0;
            ref_ff   <= '0;
            brake_ff <= 1'b0;
            coast_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_NORMAL: begin
                    brake_ff <= 1'b0;
                    coast_ff <= 1'b0;
                    if (cause) begin
                        state_ff <= ST_DECEL;
                        ref_ff   <= i_speed_fb;
                        pre_ff   <= '0;
                        ms_ff    <= '0;
                        acc_ff   <= '0;
                    end
                end
                ST_DECEL: begin
                    pre_ff <= ms_tick ? 17'h0_0000 : pre_ff + 17'h0_0001;
                    if (ms_tick) begin
                        ms_ff <= ms_ff + 16'h0001;
                    end
                    acc_ff <= step ? acc_sum - tc_cyc : acc_sum;
                    if (step & spinning) begin
                        ref_ff <= ref_ff - 16'h0001;
                    end
                    if (expire) begin
                        state_ff <= ST_GATE_OFF;
                        brake_ff <= spinning & ~coast_sel;
                        coast_ff <= spinning & coast_sel;
                    end else if (~spinning) begin
                        state_ff <= ST_GATE_OFF;
                    end
                end
                ST_GATE_OFF: begin
                    ref_ff <= '0;
                    if (~cause) begin
                        state_ff <= ST_NORMAL;
                    end
                end
                default: begin
                    state_ff <= ST_NORMAL;
                end
            endcase
        end
    end

    assign o_stop.estop_active   = state_ff[0];
    assign o_stop.ready          = ~state_ff[1];
    assign o_stop.dyn_brake      = brake_ff;
    assign o_stop.coast          = coast_ff;
    assign o_stop.coil_switch_en = (state_ff == ST_DECEL)
                                   & cfg_ff[IDX_FUNC_FIVE][BIT_COIL_SWITCH];
    assign o_stop.speed_alarm    = alarm_ff;
    assign o_decel_ref           = ref_ff;

    assign nxt_rdata = cfg_hit    ? {16'h0000, cfg_ff[addr_idx]} :
                       status_hit ? {26'h000_0000, coast_ff, brake_ff,
                                     state_ff, ~state_ff[1], alarm_ff} :
                       ref_hit    ? {16'h0000, ref_ff} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    AST_NOTCH_ZERO: assert property (
        cfg_ff[IDX_NOTCH_ONE] < NOTCH_MIN_HZ |=> !o_tune.notch_en[0])
        else $error("Notch one enabled below threshold.");
    AST_SYNC_GAIN: assert property (
        mode != MODE_SYNC |=> o_tune.pos_gain == 8'h00)
        else $error("Sync gain applied outside sync mode.");
    AST_HIGH_GAIN: assert property (
        sync_mode && func4[BIT_HIGH_GAIN] |=> o_tune.high_gain_tracking)
        else $error("High-gain tracking not started.");
    AST_EXCITE: assert property (
        ##1 o_tune.excite_rate_two == $past(func4[BIT_EXCITE_TWO]))
        else $error("Excitation selection does not follow word four.");
    AST_FAST_INTERP: assert property (
        interp || i_orienting |=> !o_tune.fast_accel)
        else $error("High-response active during interpolation.");
    AST_ALARM_SET: assert property (
        slow_trip |=> o_alarm_code == ALARM_SPEED_ERR [*2])
        else $error("Slowdown alarm not raised and held.");
    AST_ESTOP_ENTER: assert property (
        state_ff == ST_NORMAL && cause |=> o_stop.estop_active
        && o_stop.ready)
        else $error("Stop cause did not start deceleration.");
    AST_GATE_OFF: assert property (
        state_ff == ST_DECEL && expire |=> !o_stop.ready
        && (o_stop.dyn_brake || o_stop.coast || !$past(spinning)))
        else $error("Ready not forced off at delay expiry.");
    AST_DEFAULT_DELAY: assert property (
        gate_cfg == 16'h0000 |-> gate_ms == 16'h1b58)
        else $error("Zero gate delay not taken as 7000 ms.");
    AST_RAMP_DOWN: assert property (
        state_ff == ST_DECEL ##1 state_ff == ST_DECEL
        |-> ref_ff <= $past(ref_ff))
        else $error("Stop ramp rose.");
    AST_COIL: assert property (
        o_stop.coil_switch_en |-> o_stop.estop_active
        && cfg_ff[IDX_FUNC_FIVE][BIT_COIL_SWITCH])
        else $error("Coil switch allowed outside stop deceleration.");

    CVR_ESTOP: cover property (state_ff == ST_NORMAL ##1 state_ff == ST_DECEL);
    CVR_BRAKE: cover property ($rose(brake_ff));
    CVR_COAST: cover property ($rose(coast_ff));
    CVR_ALARM: cover property ($rose(alarm_ff));

endmodule

// file: design/setc_pkg.sv
// Package: register map, constants and carrier types of the spindle stop block.
package setc_pkg;

    // Clock and time base.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_MS     = 1000000;
    localparam int unsigned CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;

    // Configuration words, one 32-bit word each, byte offset is index times 4.
    localparam int unsigned CFG_COUNT      = 13;
    localparam logic [3:0]  IDX_NOTCH_ONE  = 4'h0;
    localparam logic [3:0]  IDX_SYNC_GAIN  = 4'h4;
    localparam logic [3:0]  IDX_FUNC_FOUR  = 4'h5;
    localparam logic [3:0]  IDX_FUNC_FIVE  = 4'h6;
    localparam logic [3:0]  IDX_GATE_DELAY = 4'h7;
    localparam logic [3:0]  IDX_DECEL_TC   = 4'h8;
    localparam logic [3:0]  IDX_LEAD_SCALE = 4'h9;
    localparam logic [3:0]  IDX_FUNC_SIX   = 4'ha;
    localparam logic [3:0]  IDX_SLOW_WIDTH = 4'hb;
    localparam logic [3:0]  IDX_MAX_SPEED  = 4'hc;
    localparam logic [5:0]  OFS_STATUS     = 6'h34;
    localparam logic [5:0]  OFS_DECEL_REF  = 6'h38;

    // Values after reset, in index order.
    localparam logic [15:0] CFG_RST [CFG_COUNT] = '{
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000f, 16'h0000,
        16'h0000, 16'h4e20, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h1770};

    // Field positions inside the function words and the status word.
    localparam int unsigned BIT_HIGH_GAIN   = 4;
    localparam int unsigned BIT_EXCITE_TWO  = 2;
    localparam int unsigned BIT_GAIN_SET    = 1;
    localparam int unsigned BIT_COIL_SWITCH = 8;
    localparam int unsigned BIT_FAST_ACCEL  = 13;
    localparam int unsigned STB_ALARM       = 0;

    // Thresholds and defaults.
    localparam logic [15:0] NOTCH_MIN_HZ     = 16'h0032;
    localparam logic [15:0] NOTCH_MAX_HZ     = 16'h08ca;
    localparam logic [15:0] ESTOP_DEFAULT_MS = 16'h1b58;
    localparam logic [6:0]  SLOW_DEFAULT_PCT = 7'h55;
    localparam logic [6:0]  PCT_FULL         = 7'h64;
    localparam logic [15:0] SLOW_DISABLE     = 16'hffff;
    localparam logic [7:0]  ALARM_SPEED_ERR  = 8'h17;

    // Control mode codes in bits 2..0 of control input word four.
    localparam logic [2:0]  MODE_SYNC     = 3'h1;
    localparam logic [2:0]  MODE_INTERP_A = 3'h2;
    localparam logic [2:0]  MODE_INTERP_B = 3'h4;

    typedef enum logic [1:0] {
        ST_NORMAL   = 2'b00,
        ST_DECEL    = 2'b01,
        ST_GATE_OFF = 2'b11
    } setc_state_e;

    typedef struct packed {
        logic [3:0]  notch_en;
        logic        sync_gain_on;
        logic [7:0]  pos_gain;
        logic        high_gain_tracking;
        logic        excite_rate_two;
        logic        gain_set_two;
        logic        fast_accel;
        logic [15:0] lead_scale;
    } setc_tune_s;

    typedef struct packed {
        logic estop_active;
        logic ready;
        logic dyn_brake;
        logic coast;
        logic coil_switch_en;
        logic speed_alarm;
    } setc_stop_s;

endpackage

// file: dv/setc_nc_model.sv
// Controller model: commands mode and speed, raises stop, opens contactor.
`timescale 1ns/1ps
module setc_nc_model
    import setc_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic [2:0]  i_mode,
    input  wire logic [15:0] i_speed,
    input  wire logic        i_stop_req,
    input  wire setc_stop_s  i_stop,
    input  wire logic [15:0] i_speed_fb,
    output logic      [15:0] o_ctrl_in4,
    output logic      [15:0] o_speed_cmd,
    output logic             o_estop,
    output logic             o_contactor_off
);
    // Bits above the mode field carry unrelated traffic every cycle.
    always @(posedge i_clk_sys) begin
        o_ctrl_in4 <= {13'($urandom()), i_mode};
        o_speed_cmd <= i_speed;
        o_estop <= i_stop_req;
        // The contactor opens only once zero speed is confirmed.
        o_contactor_off <= i_stop.estop_active && i_speed_fb == 16'h0;
    end
endmodule

// file: dv/setc_tb.sv
// Self-checking bench of the spindle stop and tuning block.
`timescale 1ns/1ps
module testbench;
    import setc_pkg::*;
    localparam int P = 10;
    localparam logic [15:0] NCRN [4] = '{16'h0, 16'h31, 16'h32, 16'h8ca};
    localparam logic [47:0] SCRN [6] = '{
        {16'h5a, 16'h3e8, 16'h65}, {16'h5a, 16'h3e8, 16'h64},
        {16'h0, 16'h3e8, 16'h97}, {16'h0, 16'h3e8, 16'h96},
        {16'hffff, 16'h3e8, 16'h0}, {16'h96, 16'h3e8, 16'h0}};
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [5:0]  addr = 6'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic [15:0] ctrl4, cmd, dref;
    logic [15:0] fb = 16'h0;
    logic [15:0] speed = 16'h0;
    logic [2:0]  mode = 3'h0;
    logic        orient = 1'b0;
    logic        stop_req = 1'b0;
    logic        pdown = 1'b0;
    logic        ualarm = 1'b0;
    logic        estop, cont;
    logic [7:0]  acode;
    setc_tune_s  tune;
    setc_stop_s  stp;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cyc = 0;
    always #5 clk = ~clk;
    setc_ctrl #(.P_CYC_PER_MS(P)) setc_ctrl_inst (
        .i_clk_sys(clk), .i_srst(srst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_ctrl_in4(ctrl4),
        .i_orienting(orient), .i_speed_cmd(cmd), .i_speed_fb(fb),
        .i_estop(estop), .i_nc_power_down(pdown), .i_unit_alarm(ualarm),
        .o_tune(tune), .o_stop(stp), .o_decel_ref(dref), .o_alarm_code(acode));
    setc_nc_model setc_nc_model_inst (
        .i_clk_sys(clk), .i_mode(mode), .i_speed(speed),
        .i_stop_req(stop_req), .i_stop(stp), .i_speed_fb(fb),
        .o_ctrl_in4(ctrl4), .o_speed_cmd(cmd), .o_estop(estop),
        .o_contactor_off(cont));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [15:0] d, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {16'h0, d};
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic put(input logic [3:0] idx, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, {idx, 2'b00}, d, q);
    endtask
    function automatic logic slow_exp(logic [15:0] w, c, f);
        int p;
        p = (w == 16'h0) ? 85 : (w > 16'h64) ? 100 : int'(w);
        return w != 16'hffff && c != 0 && int'(f) * 100 <= int'(c) * (100 - p);
    endfunction
    // Drops every cause and the sticky alarm, then expects normal running.
    task automatic recover;
        int n;
        logic [31:0] q;
        n = 0;
        stop_req <= 1'b0;
        pdown <= 1'b0;
        ualarm <= 1'b0;
        speed <= 16'h0;
        fb <= 16'h0;
        while (stp.estop_active === 1'b1 && stp.ready === 1'b1 && n < 90000) begin
            @(posedge clk);
            n++;
        end
        bus(1'b1, OFS_STATUS, 16'h1, q);
        repeat (8) @(posedge clk);
        check({stp.ready, stp.estop_active}, 2'b10);
        check(cont, 1'b0);
    endtask
    task automatic stop_run(input int cause, f, tc, dl, ms, input logic coil,
                            output int drop);
        int tce, dle, cnt;
        logic [15:0] r0;
        tce = (tc == 0) ? 7000 : tc;
        dle = (dl == 0) ? 7000 : dl;
        drop = 0;
        put(IDX_GATE_DELAY, 16'(dl));
        put(IDX_DECEL_TC, 16'(tc));
        put(IDX_MAX_SPEED, 16'(ms));
        put(IDX_FUNC_FIVE, {7'h0, coil, 8'h0});
        fb <= 16'(f);
        @(posedge clk);
        stop_req <= cause == 0;
        pdown <= cause == 1;
        ualarm <= cause == 2;
        cnt = 0;
        while (stp.estop_active !== 1'b1 && cnt < 20) begin
            @(posedge clk);
            cnt++;
        end
        check(cnt < 12, 1'b1);
        r0 = dref;
        cnt = 0;
        while (stp.ready === 1'b1 && cnt < 80000) begin
            @(posedge clk);
            cnt++;
            if (cnt == 5) check(stp.coil_switch_en, coil);
            if (cnt == 40) drop = int'(r0) - int'(dref);
        end
        check(cnt >= dle * P - 12 && cnt <= dle * P + 12, 1'b1);
        check(stp.coast, tce > dle);
        check(stp.dyn_brake, tce <= dle);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            mismatches++;
            finish_test;
        end
    end
    initial begin
        logic [31:0] q;
        logic [15:0] nv [4];
        logic [15:0] g, f4, f6, ls, w, c, f;
        setc_tune_s e;
        int drop;
        void'($urandom(32'h7d19064f));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < CFG_COUNT; i++) begin
            bus(1'b0, 6'(i * 4), 16'h0, q);
            check(q, {16'h0, CFG_RST[i]});
        end
        put(4'hf, 16'h5a5a);
        bus(1'b0, 6'h3c, 16'h0, q);
        check(q, 32'h0);
        for (int i = 0; i < 24; i++) begin
            for (int k = 0; k < 4; k++) begin
                nv[k] = (i < 4) ? NCRN[(i + k) % 4] : 16'($urandom_range(2250));
                put(IDX_NOTCH_ONE + 4'(k), nv[k]);
                e.notch_en[k] = nv[k] >= 16'h32;
            end
            g = 16'($urandom_range(200, 1));
            f4 = 16'($urandom());
            f6 = 16'($urandom());
            ls = 16'($urandom_range(10000));
            put(IDX_SYNC_GAIN, g);
            put(IDX_FUNC_FOUR, f4);
            put(IDX_FUNC_SIX, f6);
            put(IDX_LEAD_SCALE, ls);
            mode <= 3'(i);
            orient <= i[3];
            repeat (4) @(posedge clk);
            e.sync_gain_on = mode == 3'h1;
            e.pos_gain = (mode == 3'h1) ? g[7:0] : 8'h00;
            e.high_gain_tracking = f4[4] && mode == 3'h1;
            e.excite_rate_two = f4[2];
            e.gain_set_two = f4[1];
            e.fast_accel = f6[13] && !orient && !(mode inside {3'h1, 3'h2, 3'h4});
            e.lead_scale = e.fast_accel ? ls : 16'h0;
            check(48'(tune), 48'(e));
        end
        mode <= 3'h0;
        put(IDX_GATE_DELAY, 16'h1);
        put(IDX_DECEL_TC, 16'h1);
        for (int i = 0; i < 26; i++) begin
            if (i < 6) {w, c, f} = SCRN[i];
            else begin
                w = 16'($urandom_range(100));
                c = 16'($urandom_range(6000, 1));
                f = 16'($urandom_range(c));
            end
            put(IDX_SLOW_WIDTH, w);
            speed <= c;
            fb <= f;
            repeat (6) @(posedge clk);
            check(stp.speed_alarm, slow_exp(w, c, f));
            check(acode, slow_exp(w, c, f) ? 8'h17 : 8'h0);
            recover;
        end
        stop_run(0, 1000, 5, 5, 6000, 1'b1, drop);
        recover;
        stop_run(1, 3000, 50, 10, 100, 1'b0, drop);
        check(drop >= 7 && drop <= 9, 1'b1);
        recover;
        stop_run(2, 1500, 50, 10, 100, 1'b0, drop);
        check(drop >= 7 && drop <= 9, 1'b1);
        recover;
        stop_run(0, 6000, 0, 0, 3000, 1'b0, drop);
        recover;
        finish_test;
    end
endmodule
